// ---- tcs_pkg.sv ----
package tcs_pkg;

  // Sizing defaults.
  localparam int NUM_SLOTS_DEF = 4;
  localparam int NUM_VCPU_DEF  = 2;
  localparam int BOOT_VCPU     = 0;

  // Reset values; the vector value is arbitrary.
  localparam logic [31:0] RESET_VECTOR_DEF = 32'h0000_0000;
  localparam logic [31:0] VCPU_CTRL_RST    = 32'h0000_0001;

  // Register byte offsets.
  localparam logic [7:0] A_SLOT_SEL  = 8'h00;
  localparam logic [7:0] A_SLOT_CTRL = 8'h04;
  localparam logic [7:0] A_SLOT_STAT = 8'h08;
  localparam logic [7:0] A_SLOT_PC   = 8'h0c;
  localparam logic [7:0] A_USER_PTR  = 8'h10;
  localparam logic [7:0] A_VCPU_CTRL = 8'h14;

  // Field positions of the slot control register.
  localparam int F_ACT   = 0;
  localparam int F_ALLOC = 1;
  localparam int F_HALT  = 2;
  localparam int F_PARK  = 3;
  localparam int F_STEP  = 4;
  localparam int F_MEDIA = 5;
  localparam int F_PRIV  = 6;
  localparam int F_CU    = 8;
  localparam int F_TAG   = 12;

  // Field positions of the slot status register.
  localparam int F_ST_ACT  = 0;
  localparam int F_ST_BLK  = 8;
  localparam int F_ST_SUSP = 16;
  localparam int F_ST_ELIG = 24;

  // Bit of the per-virtual-CPU control register.
  localparam int F_VC_OPEN = 0;

  // Selector values of the move port.
  localparam logic MV_PC   = 1'b0;
  localparam logic MV_UPTR = 1'b1;

endpackage : tcs_pkg

// ---- tcs_rr_arb.sv ----
`timescale 1ns/1ns

module tcs_rr_arb #(
  parameter int N  = 4,
  parameter int SW = 2
) (
  // Clock and reset.
  input  wire logic          i_clock,
  input  wire logic          i_resetn,
  input  wire logic          i_clk_en,
  // Requests and grant.
  input  wire logic [N-1:0]  i_req,
  input  wire logic          i_take,
  output logic               o_valid,
  output logic [SW-1:0]      o_slot
);

  logic [SW-1:0] ptr_r;

  // Searches from the slot after the last winner so no slot can hog fetch.
  always_comb begin
    int k;
    k = 0;
    o_valid = 1'b0;
    o_slot  = '0;
    for (int j = N; j >= 1; j--) begin
      k = (int'(ptr_r) + j) % N;
      if (i_req[k]) begin
        o_valid = 1'b1;
        o_slot  = SW'(k);
      end
    end
  end

  always_ff @(posedge i_clock) begin
    if (!i_resetn) begin
      ptr_r <= SW'(N - 1);
    end else if (i_clk_en && o_valid && i_take) begin
      ptr_r <= o_slot;
    end
  end

endmodule // tcs_rr_arb

// ---- tcs_thread_ctrl.sv ----
`timescale 1ns/1ns

// Summary of operation
// - Free slots are never fetched or issued.
// - Activated slots are scheduled from own counter.
// - Spawn allocates only free slots.
// - Software and thread ops both allocate slots.
// - Thread ops touch only designated slots.
// - Unsatisfied synchronization keeps a slot blocked.
// - Halted slots neither spawned into nor fetched.
// - Halted slot state stays stable.
// - Suspended slots cannot raise exceptions.
// - Debug-parked slots are never scheduled.
// - Privileged move reaches target slot state.
// - Gating-store access blocks until partner acts.
// - Each slot keeps its own context state.
// - Privileged state per CPU; each has slots.
// - One virtual CPU starts at reset.
// - Exception suspends sibling slots until flags clear.
// - Blocked slots cannot monopolize shared fetch.
module tcs_thread_ctrl #(
  parameter int          NUM_SLOTS    = tcs_pkg::NUM_SLOTS_DEF,
  parameter int          NUM_VCPU     = tcs_pkg::NUM_VCPU_DEF,
  parameter logic [31:0] RESET_VECTOR = tcs_pkg::RESET_VECTOR_DEF,
  localparam int         SW           = (NUM_SLOTS > 1) ? $clog2(NUM_SLOTS) : 1,
  localparam int         VW           = (NUM_VCPU > 1) ? $clog2(NUM_VCPU) : 1
) (
  // Clock, reset and enable.
  input  wire logic                 i_clock,
  input  wire logic                 i_resetn,
  input  wire logic                 i_clk_en,
  // APB slave.
  input  wire logic                 i_psel,
  input  wire logic                 i_penable,
  input  wire logic                 i_pwrite,
  input  wire logic [7:0]           i_paddr,
  input  wire logic [31:0]          i_pwdata,
  output logic                      o_pready,
  output logic [31:0]               o_prdata,
  output logic                      o_pslverr,
  // Spawn request.
  input  wire logic                 i_spawn_req,
  input  wire logic [VW-1:0]        i_spawn_vcpu,
  input  wire logic [31:0]          i_spawn_pc,
  output logic                      o_spawn_done,
  output logic                      o_spawn_ok,
  output logic [SW-1:0]             o_spawn_slot,
  // Thread_op_a (deallocate) request.
  input  wire logic                 i_thread_op_a_req,
  input  wire logic [SW-1:0]        i_thread_op_a_slot,
  output logic                      o_thread_op_a_done,
  output logic                      o_thread_op_a_ok,
  // Synchronization and gating-store blocking.
  input  wire logic [NUM_SLOTS-1:0] i_block_set,
  input  wire logic [NUM_SLOTS-1:0] i_block_clr,
  // Exceptions.
  input  wire logic                 i_exc_take,
  input  wire logic [SW-1:0]        i_exc_slot,
  input  wire logic [NUM_VCPU-1:0]  i_exc_level,
  input  wire logic [NUM_VCPU-1:0]  i_err_level,
  // Program counter update from the pipeline.
  input  wire logic                 i_pc_wr,
  input  wire logic [SW-1:0]        i_pc_slot,
  input  wire logic [31:0]          i_pc_val,
  // Move to or from a target slot.
  input  wire logic                 i_mv_req,
  input  wire logic                 i_mv_wr,
  input  wire logic                 i_mv_priv,
  input  wire logic                 i_mv_sel,
  input  wire logic [SW-1:0]        i_mv_slot,
  input  wire logic [31:0]          i_mv_wdata,
  output logic                      o_mv_done,
  output logic                      o_mv_ok,
  output logic [31:0]               o_mv_rdata,
  // Fetch scheduling.
  input  wire logic                 i_fetch_ready,
  output logic                      o_fetch_valid,
  output logic [SW-1:0]             o_fetch_slot,
  output logic [31:0]               o_fetch_pc,
  // Slot status.
  output logic [NUM_SLOTS-1:0]      o_eligible,
  output logic [NUM_SLOTS-1:0]      o_may_except,
  output logic [NUM_SLOTS-1:0]      o_stable
);

  import tcs_pkg::*;

  localparam int                   SPV       = NUM_SLOTS / NUM_VCPU;
  localparam logic [NUM_SLOTS-1:0] BOOT_MASK = NUM_SLOTS'(1) << (BOOT_VCPU * SPV);

  ////////////////////////////////////////////////////////////////////////////
  // Helpers.

  // Slots are bound to virtual CPUs in equal contiguous groups.
  function automatic logic [VW-1:0] vcpu_of(input logic [SW-1:0] s);
    return VW'(int'(s) / SPV);
  endfunction

  function automatic logic [NUM_SLOTS-1:0] vcpu_mask(input logic [VW-1:0] v);
    logic [NUM_SLOTS-1:0] m;
    m = '0;
    for (int i = 0; i < NUM_SLOTS; i++) begin
      m[i] = (int'(v) == i / SPV);
    end
    return m;
  endfunction

  function automatic logic [7:0] zext8(input logic [NUM_SLOTS-1:0] v);
    logic [7:0] r;
    r = '0;
    for (int i = 0; i < NUM_SLOTS && i < 8; i++) begin
      r[i] = v[i];
    end
    return r;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // State.

  logic [NUM_SLOTS-1:0] act_r;
  logic [NUM_SLOTS-1:0] alloc_r;
  logic [NUM_SLOTS-1:0] halt_r;
  logic [NUM_SLOTS-1:0] park_r;
  logic [NUM_SLOTS-1:0] step_r;
  logic [NUM_SLOTS-1:0] media_r;
  logic [NUM_SLOTS-1:0] blk_r;
  logic [NUM_SLOTS-1:0] susp_r;
  logic [1:0]           priv_r [NUM_SLOTS];
  logic [3:0]           cu_r   [NUM_SLOTS];
  logic [7:0]           tag_r  [NUM_SLOTS];
  logic [31:0]          pc_r   [NUM_SLOTS];
  logic [31:0]          uptr_r [NUM_SLOTS];
  logic [31:0]          vctrl_r [NUM_VCPU];
  logic [NUM_VCPU-1:0]  lvl_q;
  logic [SW-1:0]        sel_r;
  logic                 pready_r;

  ////////////////////////////////////////////////////////////////////////////
  // Decode.

  logic                 apb_wr;
  logic                 wr_sel;
  logic                 wr_ctrl;
  logic                 wr_pc;
  logic                 wr_uptr;
  logic                 wr_vctrl;
  logic                 hit;
  logic [NUM_SLOTS-1:0] cand;
  logic                 spawn_ok;
  logic [SW-1:0]        spawn_slot;
  logic                 yld_ok;
  logic                 mv_ok;
  logic [NUM_SLOTS-1:0] elig;
  logic [NUM_VCPU-1:0]  lvl;
  logic [NUM_VCPU-1:0]  vc_open;
  logic                 arb_valid;
  logic [SW-1:0]        arb_slot;

  assign apb_wr   = i_psel && i_penable && pready_r && i_pwrite;
  assign wr_sel   = apb_wr && (i_paddr == A_SLOT_SEL);
  assign wr_ctrl  = apb_wr && (i_paddr == A_SLOT_CTRL);
  assign wr_pc    = apb_wr && (i_paddr == A_SLOT_PC);
  assign wr_uptr  = apb_wr && (i_paddr == A_USER_PTR);
  assign wr_vctrl = apb_wr && (i_paddr == A_VCPU_CTRL);
  assign hit      = (i_paddr == A_SLOT_SEL) || (i_paddr == A_SLOT_CTRL) ||
                    (i_paddr == A_SLOT_STAT) || (i_paddr == A_SLOT_PC) ||
                    (i_paddr == A_USER_PTR) || (i_paddr == A_VCPU_CTRL);
  assign lvl      = i_exc_level | i_err_level;

  always_comb begin
    for (int v = 0; v < NUM_VCPU; v++) begin
      vc_open[v] = vctrl_r[v][F_VC_OPEN];
    end
  end

  // Spawn candidates: free, designated, not halted, in the asked virtual CPU.
  assign cand = ~act_r & alloc_r & ~halt_r & vcpu_mask(i_spawn_vcpu)
                & {NUM_SLOTS{vc_open[i_spawn_vcpu]}};
  assign spawn_ok = i_spawn_req && (|cand);

  always_comb begin
    spawn_slot = '0;
    for (int i = NUM_SLOTS - 1; i >= 0; i--) begin
      if (cand[i]) begin
        spawn_slot = SW'(i);
      end
    end
  end

  // A thread_op_a frees only an activated, designated slot.
  assign yld_ok = i_thread_op_a_req && act_r[i_thread_op_a_slot] && alloc_r[i_thread_op_a_slot]
                  && vc_open[vcpu_of(i_thread_op_a_slot)];

  assign mv_ok = i_mv_req && i_mv_priv;

  // Fetch needs every condition at once.
  assign elig = act_r & ~blk_r & ~halt_r & ~susp_r & ~park_r;

  ////////////////////////////////////////////////////////////////////////////
  // Allocation, halt and park state.

  always_ff @(posedge i_clock) begin
    if (!i_resetn) begin
      act_r   <= BOOT_MASK;
      alloc_r <= '0;
      halt_r  <= '0;
      park_r  <= '0;
    end else if (i_clk_en) begin
      if (spawn_ok) begin
        act_r[spawn_slot] <= 1'b1;
      end
      if (yld_ok) begin
        act_r[i_thread_op_a_slot] <= 1'b0;
      end
      // Software writes come last so they win over a thread op on the slot.
      if (wr_ctrl) begin
        act_r[sel_r]   <= i_pwdata[F_ACT];
        alloc_r[sel_r] <= i_pwdata[F_ALLOC];
        halt_r[sel_r]  <= i_pwdata[F_HALT];
        park_r[sel_r]  <= i_pwdata[F_PARK];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Per-slot context fields.

  always_ff @(posedge i_clock) begin
    if (!i_resetn) begin
      step_r  <= '0;
      media_r <= '0;
      for (int i = 0; i < NUM_SLOTS; i++) begin
        priv_r[i] <= '0;
        cu_r[i]   <= '0;
        tag_r[i]  <= '0;
      end
    end else if (i_clk_en && wr_ctrl) begin
      step_r[sel_r]  <= i_pwdata[F_STEP];
      media_r[sel_r] <= i_pwdata[F_MEDIA];
      priv_r[sel_r]  <= i_pwdata[F_PRIV +: 2];
      cu_r[sel_r]    <= i_pwdata[F_CU +: 4];
      tag_r[sel_r]   <= i_pwdata[F_TAG +: 8];
    end
  end

  // Program counter: pipeline updates skip halted slots so they stay stable.
  always_ff @(posedge i_clock) begin
    if (!i_resetn) begin
      for (int i = 0; i < NUM_SLOTS; i++) begin
        pc_r[i] <= RESET_VECTOR;
      end
    end else if (i_clk_en) begin
      if (i_pc_wr && !halt_r[i_pc_slot]) begin
        pc_r[i_pc_slot] <= i_pc_val;
      end
      if (spawn_ok) begin
        pc_r[spawn_slot] <= i_spawn_pc;
      end
      if (mv_ok && i_mv_wr && i_mv_sel == MV_PC) begin
        pc_r[i_mv_slot] <= i_mv_wdata;
      end
      if (wr_pc) begin
        pc_r[sel_r] <= i_pwdata;
      end
    end
  end

  always_ff @(posedge i_clock) begin
    if (!i_resetn) begin
      for (int i = 0; i < NUM_SLOTS; i++) begin
        uptr_r[i] <= '0;
      end
    end else if (i_clk_en) begin
      if (mv_ok && i_mv_wr && i_mv_sel == MV_UPTR) begin
        uptr_r[i_mv_slot] <= i_mv_wdata;
      end
      if (wr_uptr) begin
        uptr_r[sel_r] <= i_pwdata;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Blocking and suspension.

  // A slot stays blocked until released; a new block wins over a release.
  always_ff @(posedge i_clock) begin
    if (!i_resetn) begin
      blk_r <= '0;
    end else if (i_clk_en) begin
      blk_r <= ((blk_r & ~i_block_clr) | i_block_set) & act_r;
    end
  end

  // Siblings are released when both level flags of their CPU fall.
  always_ff @(posedge i_clock) begin
    if (!i_resetn) begin
      susp_r <= '0;
      lvl_q  <= '0;
    end else if (i_clk_en) begin
      lvl_q <= lvl;
      for (int i = 0; i < NUM_SLOTS; i++) begin
        if (i_exc_take && vcpu_of(SW'(i)) == vcpu_of(i_exc_slot) && SW'(i) != i_exc_slot) begin
          susp_r[i] <= 1'b1;
        end else if (lvl_q[vcpu_of(SW'(i))] && !lvl[vcpu_of(SW'(i))]) begin
          susp_r[i] <= 1'b0;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Fetch scheduling.

  tcs_rr_arb #(
    .N  (NUM_SLOTS),
    .SW (SW)
  ) u_arb (
    .i_clock  (i_clock),
    .i_resetn (i_resetn),
    .i_clk_en (i_clk_en),
    .i_req    (elig),
    .i_take   (i_fetch_ready),
    .o_valid  (arb_valid),
    .o_slot   (arb_slot)
  );

  // Blocked or suspended slots never hold the fetch grant.
  always_ff @(posedge i_clock) begin
    if (!i_resetn) begin
      o_fetch_valid <= 1'b0;
      o_fetch_slot  <= '0;
      o_fetch_pc    <= '0;
    end else if (i_clk_en) begin
      o_fetch_valid <= arb_valid;
      o_fetch_slot  <= arb_slot;
      o_fetch_pc    <= pc_r[arb_slot];
    end
  end

  always_ff @(posedge i_clock) begin
    if (!i_resetn) begin
      o_eligible   <= '0;
      o_may_except <= '0;
      o_stable     <= '0;
    end else if (i_clk_en) begin
      o_eligible   <= elig;
      o_may_except <= act_r & ~susp_r;
      o_stable     <= halt_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Thread op and move answers.

  always_ff @(posedge i_clock) begin
    if (!i_resetn) begin
      o_spawn_done <= 1'b0;
      o_spawn_ok   <= 1'b0;
      o_spawn_slot <= '0;
      o_thread_op_a_done <= 1'b0;
      o_thread_op_a_ok   <= 1'b0;
    end else if (i_clk_en) begin
      o_spawn_done <= i_spawn_req;
      o_spawn_ok   <= spawn_ok;
      o_spawn_slot <= spawn_slot;
      o_thread_op_a_done <= i_thread_op_a_req;
      o_thread_op_a_ok   <= yld_ok;
    end
  end

  always_ff @(posedge i_clock) begin
    if (!i_resetn) begin
      o_mv_done  <= 1'b0;
      o_mv_ok    <= 1'b0;
      o_mv_rdata <= '0;
    end else if (i_clk_en) begin
      o_mv_done  <= i_mv_req;
      o_mv_ok    <= mv_ok;
      o_mv_rdata <= !mv_ok ? 32'h0000_0000 :
                    (i_mv_sel == MV_PC) ? pc_r[i_mv_slot] : uptr_r[i_mv_slot];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // APB slave.

  always_ff @(posedge i_clock) begin
    if (!i_resetn) begin
      sel_r <= '0;
      for (int v = 0; v < NUM_VCPU; v++) begin
        vctrl_r[v] <= VCPU_CTRL_RST;
      end
    end else if (i_clk_en) begin
      if (wr_sel) begin
        sel_r <= i_pwdata[SW-1:0];
      end
      if (wr_vctrl) begin
        vctrl_r[vcpu_of(sel_r)] <= i_pwdata;
      end
    end
  end

  // One wait state: pready rises in the second access cycle.
  always_ff @(posedge i_clock) begin
    if (!i_resetn) begin
      pready_r  <= 1'b0;
      o_prdata  <= '0;
      o_pslverr <= 1'b0;
    end else if (i_clk_en) begin
      pready_r  <= i_psel && i_penable && !pready_r;
      o_pslverr <= i_psel && i_penable && !pready_r && !hit;
      o_prdata  <= '0;
      if (i_psel && i_penable && !pready_r && !i_pwrite) begin
        unique case (i_paddr)
          A_SLOT_SEL:  o_prdata <= 32'(sel_r);
          A_SLOT_CTRL: o_prdata <= {12'h000, tag_r[sel_r], cu_r[sel_r], priv_r[sel_r],
                                    media_r[sel_r], step_r[sel_r], park_r[sel_r],
                                    halt_r[sel_r], alloc_r[sel_r], act_r[sel_r]};
          A_SLOT_STAT: o_prdata <= {zext8(elig), zext8(susp_r), zext8(blk_r), zext8(act_r)};
          A_SLOT_PC:   o_prdata <= pc_r[sel_r];
          A_USER_PTR:  o_prdata <= uptr_r[sel_r];
          A_VCPU_CTRL: o_prdata <= vctrl_r[vcpu_of(sel_r)];
          default:     o_prdata <= '0;
        endcase
      end
    end
  end

  assign o_pready = pready_r;

endmodule // tcs_thread_ctrl

// ---- tcs_thread_ctrl_properties.sv ----
`timescale 1ns/1ns

module tcs_thread_ctrl_chk #(
  parameter int NUM_SLOTS = 4,
  parameter int SW        = 2
) (
  // Clock, reset and bus.
  input wire logic                 i_clock,
  input wire logic                 i_resetn,
  input wire logic                 i_clk_en,
  input wire logic                 i_psel,
  input wire logic                 i_penable,
  input wire logic                 o_pready,
  // Thread operations and status.
  input wire logic                 i_spawn_req,
  input wire logic                 o_spawn_done,
  input wire logic                 i_thread_op_a_req,
  input wire logic                 o_thread_op_a_done,
  input wire logic                 i_mv_req,
  input wire logic                 i_mv_priv,
  input wire logic                 o_mv_done,
  input wire logic                 o_mv_ok,
  input wire logic [NUM_SLOTS-1:0] i_block_set,
  input wire logic                 o_fetch_valid,
  input wire logic [SW-1:0]        o_fetch_slot,
  input wire logic [NUM_SLOTS-1:0] o_eligible,
  input wire logic [NUM_SLOTS-1:0] o_may_except,
  input wire logic [NUM_SLOTS-1:0] o_stable
);
  default clocking cb @(posedge i_clock);
  endclocking
  default disable iff (!i_resetn || !i_clk_en);

  sequence s_setup;
    i_psel && !i_penable;
  endsequence
  sequence s_access;
    i_psel && i_penable;
  endsequence

  property p_apb_wait;
    s_setup ##1 s_access |-> !o_pready ##1 o_pready;
  endproperty
  property p_pready_pulse;
    o_pready |=> !o_pready;
  endproperty
  property p_fetch_elig;
    o_fetch_valid |-> o_eligible[o_fetch_slot];
  endproperty
  property p_halt_idle;
    (o_stable & o_eligible) == '0;
  endproperty
  property p_susp_idle;
    (o_eligible & ~o_may_except) == '0;
  endproperty
  property p_spawn_ans;
    i_spawn_req |=> o_spawn_done;
  endproperty
  property p_spawn_cause;
    o_spawn_done |-> $past(i_spawn_req);
  endproperty
  property p_thread_op_a_ans;
    i_thread_op_a_req |=> o_thread_op_a_done;
  endproperty
  property p_move;
    i_mv_req |=> o_mv_done && (o_mv_ok == $past(i_mv_priv));
  endproperty
  property p_block;
    (i_block_set != '0) |-> ##2 ((o_eligible & $past(i_block_set, 2)) == '0);
  endproperty

  a_apb_wait: assert property (p_apb_wait) else $error("pready not in second access cycle");
  a_pready_pulse: assert property (p_pready_pulse) else $error("pready longer than one cycle");
  a_fetch_elig: assert property (p_fetch_elig) else $error("grant to ineligible slot");
  a_halt_idle: assert property (p_halt_idle) else $error("halted slot eligible");
  a_susp_idle: assert property (p_susp_idle) else $error("suspended slot eligible");
  a_spawn_ans: assert property (p_spawn_ans) else $error("spawn not answered");
  a_spawn_cause: assert property (p_spawn_cause) else $error("spawn done without request");
  a_thread_op_a_ans: assert property (p_thread_op_a_ans) else $error("thread_op_a not answered");
  a_move: assert property (p_move) else $error("move answer wrong");
  a_block: assert property (p_block) else $error("blocked slot still eligible");
endmodule // tcs_thread_ctrl_chk

bind tcs_thread_ctrl tcs_thread_ctrl_chk #(.NUM_SLOTS(NUM_SLOTS), .SW(SW)) chk_u (
  .i_clock(i_clock), .i_resetn(i_resetn), .i_clk_en(i_clk_en), .i_psel(i_psel),
  .i_penable(i_penable), .o_pready(o_pready), .i_spawn_req(i_spawn_req), .o_spawn_done(o_spawn_done),
  .i_thread_op_a_req(i_thread_op_a_req), .o_thread_op_a_done(o_thread_op_a_done), .i_mv_req(i_mv_req), .i_mv_priv(i_mv_priv),
  .o_mv_done(o_mv_done), .o_mv_ok(o_mv_ok), .i_block_set(i_block_set), .o_fetch_valid(o_fetch_valid),
  .o_fetch_slot(o_fetch_slot), .o_eligible(o_eligible), .o_may_except(o_may_except), .o_stable(o_stable));

// ---- tcs_thread_ctrl_tb.sv ----
`timescale 1ns/1ns

module tcs_thread_ctrl_tb;
  import tcs_pkg::*;

  logic        i_clock, i_resetn, i_clk_en, i_psel, i_penable, i_pwrite, i_spawn_req, i_spawn_vcpu;
  logic        i_thread_op_a_req, i_exc_take, i_pc_wr, i_mv_req, i_mv_wr, i_mv_priv, i_mv_sel, i_fetch_ready;
  logic [7:0]  i_paddr;
  logic [31:0] i_pwdata, i_spawn_pc, i_pc_val, i_mv_wdata, o_prdata, o_mv_rdata, o_fetch_pc, d;
  logic [1:0]  i_thread_op_a_slot, i_exc_slot, i_pc_slot, i_mv_slot, i_exc_level, i_err_level, o_spawn_slot, o_fetch_slot;
  logic [3:0]  i_block_set, i_block_clr, o_eligible, o_may_except, o_stable;
  logic        o_pready, o_pslverr, o_spawn_done, o_spawn_ok, o_thread_op_a_done, o_thread_op_a_ok, o_mv_done, o_mv_ok;
  logic        o_fetch_valid;
  int          fail_count, checked;

  tcs_thread_ctrl dut_u (
    .i_clock(i_clock), .i_resetn(i_resetn), .i_clk_en(i_clk_en), .i_psel(i_psel), .i_penable(i_penable),
    .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata), .o_pready(o_pready), .o_prdata(o_prdata),
    .o_pslverr(o_pslverr), .i_spawn_req(i_spawn_req), .i_spawn_vcpu(i_spawn_vcpu), .i_spawn_pc(i_spawn_pc),
    .o_spawn_done(o_spawn_done), .o_spawn_ok(o_spawn_ok), .o_spawn_slot(o_spawn_slot),
    .i_thread_op_a_req(i_thread_op_a_req), .i_thread_op_a_slot(i_thread_op_a_slot), .o_thread_op_a_done(o_thread_op_a_done),
    .o_thread_op_a_ok(o_thread_op_a_ok), .i_block_set(i_block_set), .i_block_clr(i_block_clr), .i_exc_take(i_exc_take),
    .i_exc_slot(i_exc_slot), .i_exc_level(i_exc_level), .i_err_level(i_err_level), .i_pc_wr(i_pc_wr),
    .i_pc_slot(i_pc_slot), .i_pc_val(i_pc_val), .i_mv_req(i_mv_req), .i_mv_wr(i_mv_wr), .i_mv_priv(i_mv_priv),
    .i_mv_sel(i_mv_sel), .i_mv_slot(i_mv_slot), .i_mv_wdata(i_mv_wdata), .o_mv_done(o_mv_done),
    .o_mv_ok(o_mv_ok), .o_mv_rdata(o_mv_rdata), .i_fetch_ready(i_fetch_ready), .o_fetch_valid(o_fetch_valid),
    .o_fetch_slot(o_fetch_slot), .o_fetch_pc(o_fetch_pc), .o_eligible(o_eligible),
    .o_may_except(o_may_except), .o_stable(o_stable));

  initial begin
    i_clock = 1'b0;
    forever #10 i_clock = ~i_clock;
  end

  always @(posedge i_clock) begin
    i_fetch_ready <= 1'($urandom_range(1, 0));
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic print_verdict;
    $display("Comparisons %0d, mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd,
                     output logic er);
    int n;
    @(posedge i_clock);
    i_psel <= 1'b1;
    i_pwrite <= w;
    i_paddr <= a;
    i_pwdata <= wd;
    @(posedge i_clock);
    i_penable <= 1'b1;
    n = 0;
    do begin
      @(posedge i_clock);
      n++;
    end while (o_pready !== 1'b1 && n < 20);
    if (o_pready !== 1'b1) begin
      fail_count++;
      print_verdict();
    end
    rd = o_prdata;
    er = o_pslverr;
    i_psel <= 1'b0;
    i_penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] wd);
    logic [31:0] x;
    logic        e;
    apb(1'b1, a, wd, x, e);
  endtask

  task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] exp, input logic eexp);
    logic [31:0] x;
    logic        e;
    apb(1'b0, a, 32'h0, x, e);
    chk(nm, exp, x);
    chk("pslverr", 32'(eexp), 32'(e));
  endtask

  task automatic elig(input logic [3:0] e);
    repeat (3) @(posedge i_clock);
    @(negedge i_clock);
    chk("eligible", 32'(e), 32'(o_eligible));
  endtask

  task automatic spawn(input logic [31:0] pc, input logic ok, input logic [1:0] sl);
    @(posedge i_clock);
    i_spawn_req <= 1'b1;
    i_spawn_pc <= pc;
    @(posedge i_clock);
    i_spawn_req <= 1'b0;
    @(negedge i_clock);
    chk("spawn_ok", 32'(ok), 32'(o_spawn_ok));
    if (ok) chk("spawn_slot", 32'(sl), 32'(o_spawn_slot));
  endtask

  task automatic yld(input logic [1:0] sl, input logic ok);
    @(posedge i_clock);
    i_thread_op_a_req <= 1'b1;
    i_thread_op_a_slot <= sl;
    @(posedge i_clock);
    i_thread_op_a_req <= 1'b0;
    @(negedge i_clock);
    chk("thread_op_a_ok", 32'(ok), 32'(o_thread_op_a_ok));
  endtask

  task automatic mv(input logic w, input logic pv, input logic [31:0] wd, input logic [31:0] exp);
    @(posedge i_clock);
    i_mv_req <= 1'b1;
    i_mv_wr <= w;
    i_mv_priv <= pv;
    i_mv_sel <= MV_PC;
    i_mv_slot <= 2'h1;
    i_mv_wdata <= wd;
    @(posedge i_clock);
    i_mv_req <= 1'b0;
    @(negedge i_clock);
    chk("mv_ok", 32'(pv), 32'(o_mv_ok));
    if (!w) chk("mv_rdata", exp, o_mv_rdata);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    {i_psel, i_penable, i_pwrite, i_spawn_req, i_spawn_vcpu, i_thread_op_a_req, i_exc_take, i_pc_wr} = '0;
    {i_mv_req, i_mv_wr, i_mv_priv, i_mv_sel, i_paddr, i_pwdata, i_spawn_pc} = '0;
    {i_pc_val, i_mv_wdata, i_thread_op_a_slot, i_exc_slot, i_pc_slot, i_mv_slot, i_exc_level} = '0;
    {i_err_level, i_block_set, i_block_clr} = '0;
    i_resetn = 1'b0;
    i_clk_en = 1'b1;
    fail_count = 0;
    checked = 0;
    void'($urandom(4899));
    repeat (6) @(posedge i_clock);
    i_resetn <= 1'b1;
    elig(4'h1);
    chk("fetch", 32'h8000_0000, {o_fetch_valid, 29'h0, o_fetch_slot});
    chk("fetch_pc", RESET_VECTOR_DEF, o_fetch_pc);
    rdc("stat", A_SLOT_STAT, 32'h0100_0001, 1'b0);
    rdc("vcpu", A_VCPU_CTRL, VCPU_CTRL_RST, 1'b0);
    rdc("unmapped", 8'h18, 32'h0, 1'b1);
    $display("Reset and map test done");
    d = $urandom;
    spawn(d, 1'b0, 2'h0);
    wr(A_SLOT_SEL, 32'h1);
    wr(A_SLOT_CTRL, 32'h6);
    spawn(d, 1'b0, 2'h0);
    wr(A_SLOT_CTRL, 32'h2);
    spawn(d, 1'b1, 2'h1);
    rdc("pc", A_SLOT_PC, d, 1'b0);
    spawn(d, 1'b0, 2'h0);
    elig(4'h3);
    wr(A_SLOT_CTRL, 32'hb);
    elig(4'h1);
    wr(A_SLOT_CTRL, 32'h3);
    elig(4'h3);
    $display("Spawn and park test done");
    @(posedge i_clock);
    i_block_set <= 4'h2;
    @(posedge i_clock);
    i_block_set <= 4'h0;
    repeat (8) @(posedge i_clock);
    elig(4'h1);
    @(posedge i_clock);
    i_block_clr <= 4'h2;
    @(posedge i_clock);
    i_block_clr <= 4'h0;
    elig(4'h3);
    @(posedge i_clock);
    i_exc_take <= 1'b1;
    i_exc_slot <= 2'h0;
    i_exc_level <= 2'h1;
    i_err_level <= 2'h1;
    @(posedge i_clock);
    i_exc_take <= 1'b0;
    elig(4'h1);
    chk("may_except", 32'h1, 32'(o_may_except));
    @(posedge i_clock);
    i_exc_level <= 2'h0;
    elig(4'h1);
    @(posedge i_clock);
    i_err_level <= 2'h0;
    elig(4'h3);
    $display("Block and exception test done");
    d = $urandom;
    mv(1'b1, 1'b1, d, 32'h0);
    mv(1'b0, 1'b1, 32'h0, d);
    mv(1'b0, 1'b0, 32'h0, 32'h0);
    wr(A_USER_PTR, ~d);
    rdc("uptr", A_USER_PTR, ~d, 1'b0);
    wr(A_SLOT_CTRL, 32'h7);
    elig(4'h1);
    chk("stable", 32'h2, 32'(o_stable));
    @(posedge i_clock);
    i_pc_wr <= 1'b1;
    i_pc_slot <= 2'h1;
    i_pc_val <= ~d;
    @(posedge i_clock);
    i_pc_wr <= 1'b0;
    rdc("halted_pc", A_SLOT_PC, d, 1'b0);
    wr(A_SLOT_CTRL, 32'h3);
    wr(A_VCPU_CTRL, 32'h0);
    yld(2'h1, 1'b0);
    wr(A_VCPU_CTRL, VCPU_CTRL_RST);
    yld(2'h0, 1'b0);
    yld(2'h1, 1'b1);
    elig(4'h1);
    $display("Move, halt and thread_op_a test done");
    print_verdict();
  end
endmodule // tcs_thread_ctrl_tb
